// >>> design/asc_ctrl.sv
/*
  Sequencing control for a 12-bit successive-approximation converter:
  AHB-Lite register slave, start handshake, clock divider, busy flag,
  result formatting, pin routing and an interrupt line.
  Assumes the analog macro holds its result stable once a conversion's
  sixteenth converter clock period has passed; that result and the
  low-voltage monitor enable arrive from outside this clock domain.
*/
// Implementation choices: the placing of the registers and the AHB-Lite interface to the registers.
// Overview of operation
// - Bandgap driven only if enabled; reference on if enabled or monitor on.
// - Pin-select bit high makes its pin analog; low keeps its normal use.
// - Upper pin-select register keeps bits 1..0; bits 7..2 read zero.
// - Writing start high then low begins a conversion on the falling step.
// - Start rising resets the converter and forces the busy flag high.
// - Busy flag reads high while converting and clears when it completes.
// - Completion sets the interrupt flag; an enabled flag raises the line.
// - Clock-select divides system clock by 1,2,4,8,16,32,64; 111 undefined.
// - Converter is powered only while the power-off bit is zero.
// - Reference from supply when select low; external pin when high.
// - A conversion lasts sixteen converter clock periods.
// - Result left-aligned when format low, right-aligned when format high.
// - Channel field routes 0..9, codes above 9 pick 9; bandgap overrides.
`timescale 1ns/10ps

module asc_ctrl
  import asc_pkg::*;
#(
  parameter int RES_W = 12
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic lvm_enable_i,
  input wire logic [RES_W-1:0] conv_result_i,
  output logic conv_tick_o,
  output logic conv_reset_o,
  output logic conv_run_o,
  output asc_analog_t analog_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  asc_state_t state, next_state;
  logic lvm_meta, lvm_sync;
  logic [RES_W-1:0] res_meta, res_sync, res_q;
  logic ap_valid, ap_write, rd_pend;
  logic [7:0] ap_addr;
  logic [31:0] rd_mux;
  logic wr_en;
  logic [7:0] wdat;
  logic start, start_q, poff, fmt, bgsel, bgen, refsel;
  logic [3:0] chan;
  logic [2:0] cksel;
  logic [9:0] pin_sel;
  logic conv_busy;
  logic irq_stat, irq_en;
  logic [5:0] div_cnt, div_lim;
  logic [3:0] period_cnt;
  logic tick, start_rise, done, irq_clr;
  logic [9:0] next_route;

  // Divide code to terminal count; 111 is undefined, treated as /64
  function automatic logic [5:0] div_limit(input logic [2:0] code);
    case (code)
      3'h0: div_limit = 6'h00;
      3'h1: div_limit = 6'h01;
      3'h2: div_limit = 6'h03;
      3'h3: div_limit = 6'h07;
      3'h4: div_limit = 6'h0F;
      3'h5: div_limit = 6'h1F;
      default: div_limit = 6'h3F;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Result bus is only sampled once stable, so a plain two-stage pass
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lvm_meta <= 1'b0;
      lvm_sync <= 1'b0;
      res_meta <= '0;
      res_sync <= '0;
    end else begin
      lvm_meta <= lvm_enable_i;
      lvm_sync <= lvm_meta;
      res_meta <= conv_result_i;
      res_sync <= res_meta;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  // Address phase capture; hsize is ignored, only whole words are used
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr <= 8'h00;
    end else if (hready_i) begin
      ap_valid <= hsel_i && (htrans_i == HTRANS_NONSEQ);
      ap_write <= hwrite_i;
      ap_addr <= haddr_i[7:0];
    end
  end

  assign wr_en = ap_valid && ap_write;
  assign wdat = hwdata_i[7:0];
  assign irq_clr = wr_en && (ap_addr == OFS_IRQ_CLR) && wdat[IRQ_DONE];

  // Read data is built one cycle after the address phase so that a
  // write just before it is already visible; costs one wait state
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_pend <= 1'b0;
      hreadyout_o <= 1'b1;
      hrdata_o <= 32'h0000_0000;
      hresp_o <= 1'b0;
    end else begin
      hresp_o <= 1'b0;
      if (rd_pend) begin
        rd_pend <= 1'b0;
        hreadyout_o <= 1'b1;
        hrdata_o <= rd_mux;
      end else if (hready_i && hsel_i && (htrans_i == HTRANS_NONSEQ)
                   && !hwrite_i) begin
        rd_pend <= 1'b1;
        hreadyout_o <= 1'b0;
      end
    end
  end

  // Read mux; unmapped and write-only words read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (ap_addr)
      OFS_CTRL0: rd_mux[7:0] = {start, conv_busy, poff, fmt, chan};
      OFS_CTRL1: rd_mux[7:0] = {bgsel, bgen, 1'b0, refsel, 1'b0, cksel};
      OFS_PINL: rd_mux[7:0] = pin_sel[7:0];
      OFS_PINH: rd_mux[7:0] = {6'h00, pin_sel[9:8]};
      OFS_RESL: rd_mux[7:0] = fmt ? res_q[7:0] : {res_q[3:0], 4'h0};
      OFS_RESH: rd_mux[7:0] = fmt ? {4'h0, res_q[11:8]} : res_q[11:4];
      OFS_IRQ_STAT: rd_mux[0] = irq_stat;
      OFS_IRQ_EN: rd_mux[0] = irq_en;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start <= START_RST;
      poff <= POFF_RST;
      fmt <= 1'b0;
      chan <= 4'h0;
    end else if (wr_en && (ap_addr == OFS_CTRL0)) begin
      start <= wdat[C0_START];
      poff <= wdat[C0_POFF];
      fmt <= wdat[C0_FMT];
      chan <= wdat[3:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bgsel <= 1'b0;
      bgen <= 1'b0;
      refsel <= 1'b0;
      cksel <= 3'h0;
    end else if (wr_en && (ap_addr == OFS_CTRL1)) begin
      bgsel <= wdat[C1_BGSEL];
      bgen <= wdat[C1_BGEN];
      refsel <= wdat[C1_REFSEL];
      cksel <= wdat[2:0];
    end
  end

  // Pin selects come up as analog inputs; high bits above 1 are dropped
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_sel <= {PINH_RST, PINL_RST};
    end else if (wr_en && (ap_addr == OFS_PINL)) begin
      pin_sel[7:0] <= wdat;
    end else if (wr_en && (ap_addr == OFS_PINH)) begin
      pin_sel[9:8] <= wdat[1:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_en <= 1'b0;
    end else if (wr_en && (ap_addr == OFS_IRQ_EN)) begin
      irq_en <= wdat[IRQ_DONE];
    end
  end

  // ----------------------------------------------------------------
  // Start handshake and conversion sequencer
  // ----------------------------------------------------------------
  assign start_rise = start && !start_q;
  assign tick = (div_cnt == div_lim);
  assign done = (state == ASC_CONV) && tick && (period_cnt == PERIOD_LAST)
                && !poff && !start_rise;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_q <= START_RST;
    end else begin
      start_q <= start;
    end
  end

  // A rising start always wins: it re-arms even mid conversion
  always_comb begin
    next_state = state;
    case (state)
      ASC_IDLE: begin
        if (start_rise) next_state = ASC_ARMED;
      end
      ASC_ARMED: begin
        if (!start) next_state = poff ? ASC_IDLE : ASC_CONV;
      end
      ASC_CONV: begin
        if (start_rise) next_state = ASC_ARMED;
        else if (poff || done) next_state = ASC_IDLE;
      end
      default: next_state = ASC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ASC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Divide ratio is loaded while armed and frozen in a run so a rewrite cannot stretch it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_lim <= 6'h00;
    end else if (state == ASC_ARMED) begin
      div_lim <= div_limit(cksel);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_cnt <= 6'h00;
      period_cnt <= 4'h0;
    end else if (state != ASC_CONV || start_rise) begin
      div_cnt <= 6'h00;
      period_cnt <= 4'h0;
    end else if (tick) begin
      div_cnt <= 6'h00;
      period_cnt <= period_cnt + 4'h1;
    end else begin
      div_cnt <= div_cnt + 6'h01;
    end
  end

  // Busy comes up high and stays high until a run really completes
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      conv_busy <= BUSY_RST;
    end else if (start_rise) begin
      conv_busy <= 1'b1;
    end else if (done) begin
      conv_busy <= 1'b0;
    end
  end

  // Result lands with the busy clear, never half way through a read
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      res_q <= '0;
    end else if (done) begin
      res_q <= res_sync;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      conv_tick_o <= 1'b0;
      conv_reset_o <= 1'b0;
      conv_run_o <= 1'b0;
    end else begin
      conv_tick_o <= (state == ASC_CONV) && tick && !start_rise;
      conv_reset_o <= start_rise;
      conv_run_o <= (next_state == ASC_CONV);
    end
  end

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  // Set beats clear so a completion in the clear cycle is kept
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_stat <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      irq_stat <= done || (irq_stat && !irq_clr);
      irq_o <= irq_stat && irq_en;
    end
  end

  // ----------------------------------------------------------------
  // Analog routing and power
  // ----------------------------------------------------------------
  always_comb begin
    next_route = 10'h000;
    if (!bgsel) begin
      next_route[(chan > CH_LAST) ? CH_LAST : chan] = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // Mirrors the register reset values so routing is never empty
      analog_o <= '{pin_en: {PINH_RST, PINL_RST}, chan_route: 10'h001,
                    default: 1'b0};
    end else begin
      analog_o.pin_en <= pin_sel;
      analog_o.chan_route <= next_route;
      analog_o.bg_route <= bgsel;
      analog_o.bg_drive <= bgen;
      analog_o.bg_ref_on <= bgen || lvm_sync;
      analog_o.ref_ext <= refsel;
      analog_o.power_on <= !poff;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [10:0] cyc_cnt;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cyc_cnt <= 11'h000;
    end else if (state != ASC_CONV || start_rise) begin
      cyc_cnt <= 11'h000;
    end else begin
      cyc_cnt <= cyc_cnt + 11'h001;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_arm_busy_high: assert property (
    start_rise |=> conv_busy && conv_reset_o ##1 conv_busy)
    else $error("busy not forced high on start rise");
  chk_fall_starts_run: assert property (
    (state == ASC_ARMED && !start && !poff) |=> state == ASC_CONV)
    else $error("falling start did not begin a run");
  chk_busy_done_clear: assert property (
    done |=> !conv_busy && state == ASC_IDLE)
    else $error("busy not cleared at completion");
  chk_run_length: assert property (
    done |-> cyc_cnt == {1'b0, div_lim, 4'hF})
    else $error("conversion length is not sixteen periods");
  chk_done_irq_set: assert property (
    done |=> irq_stat ##1 (irq_o == irq_en))
    else $error("completion did not set the interrupt flag");
  chk_result_coherent: assert property (
    done |=> res_q == $past(res_sync) && !conv_busy)
    else $error("result not loaded with busy clear");
  chk_route_onehot: assert property (
    $onehot0(analog_o.chan_route)
      && (analog_o.bg_route == (analog_o.chan_route == 10'h000)))
    else $error("channel routing not exclusive");
  chk_pinh_read_zero: assert property (
    (rd_pend && ap_addr == OFS_PINH) |=> hrdata_o[31:2] == 30'h0)
    else $error("upper pin-select bits read non-zero");
  chk_power_gates_run: assert property (
    (state == ASC_CONV && poff) |=> state != ASC_CONV && conv_busy)
    else $error("run continued with converter off");
  chk_bandgap_ref: assert property (
    $past(bgen) |-> analog_o.bg_drive && analog_o.bg_ref_on)
    else $error("bandgap not on while enabled");

  cov_full_run: cover property (start_rise ##[1:40] done);
  cov_rearm_mid_run: cover property (state == ASC_CONV && start_rise);
  cov_irq_raised: cover property ($rose(irq_o));
  cov_clear_with_set: cover property (done && irq_clr);

endmodule

// >>> design/asc_pkg.sv
/*
  Shared constants and types for the converter sequencing control block.
  Assumes a 32-bit AHB-Lite register bus and a single 125 MHz clock.
*/
package asc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_PINL = 8'h08;
  localparam logic [7:0] OFS_PINH = 8'h0C;
  localparam logic [7:0] OFS_RESL = 8'h10;
  localparam logic [7:0] OFS_RESH = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFS_IRQ_EN = 8'h1C;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h20;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int C0_START = 7;
  localparam int C0_BUSY = 6;
  localparam int C0_POFF = 5;
  localparam int C0_FMT = 4;
  localparam int C1_BGSEL = 7;
  localparam int C1_BGEN = 6;
  localparam int C1_REFSEL = 4;
  localparam int IRQ_DONE = 0;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic START_RST = 1'b0;
  localparam logic BUSY_RST = 1'b1;
  localparam logic POFF_RST = 1'b1;
  localparam logic [7:0] PINL_RST = 8'hFF;
  localparam logic [1:0] PINH_RST = 2'h3;
  localparam logic [3:0] CH_LAST = 4'h9;

  // ----------------------------------------------------------------
  // Conversion timing
  // ----------------------------------------------------------------
  localparam int CONV_PERIODS = 16;
  localparam logic [3:0] PERIOD_LAST = 4'(CONV_PERIODS - 1);
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    ASC_IDLE = 2'b00,
    ASC_ARMED = 2'b01,
    ASC_CONV = 2'b10
  } asc_state_t;

  // Analog side controls, all levels
  typedef struct packed {
    logic [9:0] pin_en;
    logic [9:0] chan_route;
    logic bg_route;
    logic bg_drive;
    logic bg_ref_on;
    logic ref_ext;
    logic power_on;
  } asc_analog_t;

endpackage

// >>> tb/asc_ctrl_test.sv
/*
  Self-checking bench for the converter sequencing control block.
  Assumes asc_pkg and asc_ctrl are compiled first; the bench is the only
  bus master and also stands in for the analog macro and the monitor.
*/
`timescale 1ns/10ps

module asc_ctrl_test;
  import asc_pkg::*;

  // --------------------------------------------------------------
  // Signals and counters
  // --------------------------------------------------------------
  logic clk_i, rst_n_i, hsel_i, hwrite_i, lvm_enable_i;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
  logic [1:0] htrans_i;
  logic [2:0] hsize_i;
  logic hreadyout_o, hresp_o, conv_tick_o, conv_reset_o, conv_run_o;
  logic irq_o;
  logic [11:0] conv_result_i;
  asc_analog_t analog_o;
  logic [31:0] seed;
  int err_total, samples_checked;

  asc_ctrl dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .lvm_enable_i(lvm_enable_i), .conv_result_i(conv_result_i),
    .conv_tick_o(conv_tick_o), .conv_reset_o(conv_reset_o),
    .conv_run_o(conv_run_o), .analog_o(analog_o), .irq_o(irq_o));

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  // Xorshift keeps the run repeatable from the fixed seed
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask

  // Bounded wait for hready; the master never assumes a latency
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (hreadyout_o !== 1'b1 && n < 50);
    if (n >= 50) chk("hready wait", 32'h1, 32'h0);
  endtask

  // One single AHB-Lite transfer; read data taken at the data-phase edge
  task automatic bus(logic wr, logic [7:0] a, logic [31:0] wd);
    hsel_i <= 1'b1;
    haddr_i <= {24'h0, a};
    htrans_i <= HTRANS_NONSEQ;
    hwrite_i <= wr;
    hsize_i <= 3'h2;
    wait_ready();
    htrans_i <= 2'h0;
    hsel_i <= 1'b0;
    hwdata_i <= wr ? wd : ~wd;
    wait_ready();
    rd = hrdata_o;
    chk("hresp", 32'h0, {31'h0, hresp_o});
  endtask

  task automatic rchk(string what, logic [7:0] a, logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask

  function automatic logic [9:0] route(logic [7:0] c1, logic [3:0] ch);
    if (c1[C1_BGSEL]) return 10'h000;
    return 10'h001 << ((ch > CH_LAST) ? CH_LAST : ch);
  endfunction

  // Expected 16-bit result pair for a format setting
  function automatic logic [15:0] fmt_res(logic f, logic [11:0] r);
    return f ? {4'h0, r} : {r, 4'h0};
  endfunction

  // --------------------------------------------------------------
  // One conversion with a chosen divider, format and interrupt mask
  // --------------------------------------------------------------
  task automatic conv(logic [2:0] cs, logic f, logic en);
    int run, ticks, div, n;
    logic rst_seen;
    logic [11:0] r;
    logic [15:0] e;
    r = 12'(rnd());
    div = (cs == 3'h7) ? 64 : (1 << cs);
    conv_result_i <= r;
    bus(1'b1, OFS_IRQ_EN, {31'h0, en});
    bus(1'b1, OFS_CTRL1, {29'h0, cs});
    bus(1'b1, OFS_CTRL0, {27'h0, f, 4'h0});
    repeat (20) @(posedge clk_i); // settling after power-on
    bus(1'b1, OFS_CTRL0, {24'h0, 1'b1, 2'h0, f, 4'h0});
    rst_seen = 1'b0;
    repeat (4) begin
      @(posedge clk_i);
      rst_seen |= (conv_reset_o === 1'b1);
    end
    chk("reset pulse", 32'h1, {31'h0, rst_seen});
    rchk("busy armed", OFS_CTRL0, {27'h6, f, 4'h0});
    bus(1'b1, OFS_CTRL0, {27'h0, f, 4'h0});
    run = 0;
    ticks = 0;
    n = 0;
    while (n < 2000 && !(run > 0 && conv_run_o !== 1'b1)) begin
      @(posedge clk_i);
      n++;
      if (conv_run_o === 1'b1) run++;
      // Tick pulses trail the divider by one cycle, so the last one
      // shows in the first cycle after the run flag drops
      if (conv_tick_o === 1'b1) ticks++;
    end
    chk("run cycles", 16 * div, run);
    chk("tick count", 32'd16, ticks);
    rchk("busy done", OFS_CTRL0, {27'h0, f, 4'h0});
    e = fmt_res(f, r);
    rchk("result low", OFS_RESL, {24'h0, e[7:0]});
    rchk("result high", OFS_RESH, {24'h0, e[15:8]});
    chk("irq line", {31'h0, en}, {31'h0, irq_o});
    rchk("irq status", OFS_IRQ_STAT, 32'h1);
    bus(1'b1, OFS_IRQ_CLR, 32'h1);
    repeat (2) @(posedge clk_i);
    chk("irq cleared", 32'h0, {31'h0, irq_o});
    rchk("status cleared", OFS_IRQ_STAT, 32'h0);
    $display("test conversion sel %0d done", cs);
  endtask

  // --------------------------------------------------------------
  // Clock, watchdog and closing
  // --------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Whole run needs well under 20000 cycles; this bound cuts a hang
  initial begin
    repeat (40000) @(posedge clk_i);
    err_total++;
    end_sim();
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    logic [7:0] c0, c1, pl, ph;
    logic lvm;
    seed = 32'h98EB;
    err_total = 0;
    samples_checked = 0;
    rst_n_i = 1'b0;
    hsel_i = 1'b0;
    haddr_i = 32'h0;
    htrans_i = 2'h0;
    hwrite_i = 1'b0;
    hsize_i = 3'h2;
    hwdata_i = 32'h0;
    lvm_enable_i = 1'b0;
    conv_result_i = 12'h0;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    // Reset values of the register table
    rchk("ctrl0 reset", OFS_CTRL0, 32'h60);
    rchk("ctrl1 reset", OFS_CTRL1, 32'h0);
    rchk("pin low reset", OFS_PINL, 32'hFF);
    rchk("pin high reset", OFS_PINH, 32'h3);
    chk("pins reset", 32'h3FF, {22'h0, analog_o.pin_en});
    chk("power reset", 32'h0, {31'h0, analog_o.power_on});
    rchk("unmapped", 8'h40, 32'h0);
    bus(1'b1, OFS_PINH, 32'hFF);
    rchk("pin high mask", OFS_PINH, 32'h3);
    $display("test reset and map done");
    // Random control settings against the analog side
    for (int i = 0; i < 12; i++) begin
      c1 = 8'(rnd());
      pl = 8'(rnd());
      ph = (i == 0) ? 8'h00 : 8'(rnd());
      c0 = {3'h1, 5'(rnd())};
      lvm = 1'(rnd());
      lvm_enable_i <= lvm;
      bus(1'b1, OFS_CTRL1, {24'h0, c1});
      bus(1'b1, OFS_PINL, {24'h0, pl});
      bus(1'b1, OFS_PINH, {24'h0, ph});
      bus(1'b1, OFS_CTRL0, {24'h0, c0});
      repeat (4) @(posedge clk_i);
      rchk("ctrl1 rw", OFS_CTRL1, {24'h0, c1 & 8'hD7});
      rchk("pin low rw", OFS_PINL, {24'h0, pl});
      rchk("pin high rw", OFS_PINH, {24'h0, ph & 8'h03});
      chk("pin enables", 32'({ph[1:0], pl}), 32'(analog_o.pin_en));
      chk("chan route", 32'(route(c1, c0[3:0])),
          32'(analog_o.chan_route));
      chk("bg route", 32'(c1[C1_BGSEL]), 32'(analog_o.bg_route));
      chk("bg drive", 32'(c1[C1_BGEN]), 32'(analog_o.bg_drive));
      chk("bg ref", 32'(c1[C1_BGEN] | lvm), 32'(analog_o.bg_ref_on));
      chk("ref ext", 32'(c1[C1_REFSEL]), 32'(analog_o.ref_ext));
      chk("power off", 32'h0, {31'h0, analog_o.power_on});
    end
    $display("test analog controls done");
    // Every divider code, both formats, interrupt masked and enabled
    for (int cs = 0; cs < 8; cs++) begin
      conv(cs[2:0], cs[1], cs[0]);
    end
    // Power-off during a run aborts it and leaves the busy flag up
    bus(1'b1, OFS_CTRL1, 32'h6); // /64 gives a 512 ns period
    bus(1'b1, OFS_CTRL0, 32'h0);
    repeat (20) @(posedge clk_i); // settling after power-on
    chk("power on", 32'h1, {31'h0, analog_o.power_on});
    bus(1'b1, OFS_CTRL0, 32'h80);
    bus(1'b1, OFS_CTRL0, 32'h0);
    repeat (30) @(posedge clk_i);
    chk("running", 32'h1, {31'h0, conv_run_o});
    bus(1'b1, OFS_CTRL0, 32'h20);
    repeat (3) @(posedge clk_i);
    chk("run aborted", 32'h0, {31'h0, conv_run_o});
    rchk("busy kept", OFS_CTRL0, 32'h60);
    chk("power down", 32'h0, {31'h0, analog_o.power_on});
    $display("test power abort done");
    end_sim();
  end

endmodule
